// File: shared/clpid_regs.svh
// Constants for the closed-loop PI speed controller.
// Assumes fixed-point feedback, setpoint and speed words.
`ifndef CLPID_REGS_SVH
`define CLPID_REGS_SVH
`define CLPID_SRC_NONE      4'h0
`define CLPID_SRC_AIN53     4'h1
`define CLPID_SRC_AIN54     4'h2
`define CLPID_SRC_PULSE29   4'h3
`define CLPID_SRC_PULSE33   4'h4
`define CLPID_SRC_BUS       4'h5
`define CLPID_FB1_SRC_RST   `CLPID_SRC_AIN54
`define CLPID_FB23_SRC_RST  `CLPID_SRC_NONE
`define CLPID_CONV_LINEAR   2'h0
`define CLPID_CONV_SQRT     2'h1
`define CLPID_CONV_P2T      2'h2
`define CLPID_SENSE_NORMAL  1'b0
`define CLPID_SENSE_INVERSE 1'b1
`define CLPID_TI_MAX_S      16'h2710
`define CLPID_TICK_US       1000
`define CLPID_CLK_MHZ       25
`define CLPID_TICK_CYC      (`CLPID_TICK_US * `CLPID_CLK_MHZ)
`endif

// File: shared/clpid_pkg.sv
// Types for the closed-loop PI speed controller.
// Constants live in clpid_regs.svh.
package clpid_pkg;
  typedef enum logic [2:0] {
    CLPID_FN_SUM  = 3'h0,
    CLPID_FN_DIFF = 3'h1,
    CLPID_FN_AVG  = 3'h2,
    CLPID_FN_MIN  = 3'h3,
    CLPID_FN_MAX  = 3'h4
  } clpid_func_e;

  typedef struct packed {
    logic [3:0] src;
    logic [1:0] conv;
  } clpid_chan_s;

  typedef struct packed {
    logic        sense;
    logic [15:0] kp;
    logic [15:0] ti_s;
    logic [2:0]  func;
  } clpid_cfg_s;

  typedef enum logic [2:0] {
    CLPID_ST_IDLE  = 3'b001,
    CLPID_ST_ERR   = 3'b010,
    CLPID_ST_OUT   = 3'b100
  } clpid_state_e;
endpackage

// File: logic/clpid_core.sv
// Closed-loop PI speed controller: feedback selection, conversion,
// combining, and PI action once per control tick.
// Assumes all inputs synchronous to clock; p2t table supplied outside.
`timescale 1ns/1ns
`include "clpid_regs.svh"

module clpid_core #(
  parameter int W        = 16,
  parameter int TICK_CYC = `CLPID_TICK_CYC
) (
  // Clock and reset
  input  wire logic                  clock,
  input  wire logic                  rst,
  input  wire logic                  clk_en,
  // Source inputs
  input  wire logic signed [W-1:0]   ain53,
  input  wire logic signed [W-1:0]   ain54,
  input  wire logic signed [W-1:0]   pulse29,
  input  wire logic signed [W-1:0]   pulse33,
  input  wire logic signed [W-1:0]   bus_fb,
  // Pressure-to-temperature values from refrigerant stage
  input  wire logic signed [3*W-1:0] p2t_value,
  // Configuration
  input  wire logic                  cfg_load,
  input  wire clpid_pkg::clpid_chan_s [2:0] chan_cfg,
  input  wire clpid_pkg::clpid_cfg_s cfg,
  input  wire logic signed [3*W-1:0] setpoints,
  input  wire logic [2:0]            setpoint_used,
  input  wire logic signed [W-1:0]   ext_ref,
  // Outputs
  output logic signed [W-1:0]        speed_corr,
  output logic                       speed_valid,
  output logic signed [W-1:0]        fb_value,
  output logic signed [W-1:0]        err_value,
  output logic [3:0]                 fb1_src_reg
);
  localparam int AW = 2*W + 8;
  // Largest positive output; kept as a signed int so every clamp compare stays signed
  localparam int SMAX = 2**(W-1) - 1;

  clpid_pkg::clpid_chan_s [2:0] chan_reg;
  clpid_pkg::clpid_state_e      state_reg;
  logic [31:0]                  tick_reg;
  logic signed [AW-1:0]         integ_reg;
  logic signed [AW-1:0]         frac_reg;
  logic signed [W-1:0]          conv_fb [3];
  logic [2:0]                   fb_act;

  // Channel config registers; source unit is never stored since it
  // only matters to the display.
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      chan_reg[0] <= '{src: `CLPID_FB1_SRC_RST, conv: `CLPID_CONV_LINEAR};
      chan_reg[1] <= '{src: `CLPID_FB23_SRC_RST, conv: `CLPID_CONV_LINEAR};
      chan_reg[2] <= '{src: `CLPID_FB23_SRC_RST, conv: `CLPID_CONV_LINEAR};
    end else if (clk_en && cfg_load) begin
      chan_reg <= chan_cfg;
    end
  end

  // Source select and conversion per channel
  for (genvar c = 0; c < 3; c++) begin : g_chan
    logic signed [W-1:0] raw;
    always_comb begin
      unique case (chan_reg[c].src)
        `CLPID_SRC_AIN53:   raw = ain53;
        `CLPID_SRC_AIN54:   raw = ain54;
        `CLPID_SRC_PULSE29: raw = pulse29;
        `CLPID_SRC_PULSE33: raw = pulse33;
        `CLPID_SRC_BUS:     raw = bus_fb;
        default:            raw = '0;
      endcase
      fb_act[c] = (chan_reg[c].src != `CLPID_SRC_NONE);
      // Converted value is in the controller unit, not the source unit
      unique case (chan_reg[c].conv)
        `CLPID_CONV_P2T: conv_fb[c] = p2t_value[c*W +: W];
        `CLPID_CONV_SQRT: conv_fb[c] = raw[W-1] ? '0 : (raw >>> 1);
        default:         conv_fb[c] = raw;
      endcase
    end
  end

  // Combining of feedbacks and setpoints
  logic signed [W+1:0] fb_sum, sp_sum, fb_comb, sp_comb;
  logic signed [W-1:0] fb_min, fb_max;
  logic [1:0]          n_fb, n_sp;
  always_comb begin
    fb_sum = '0;
    sp_sum = '0;
    n_fb   = '0;
    n_sp   = '0;
    fb_min = {1'b0, {(W-1){1'b1}}};
    fb_max = {1'b1, {(W-1){1'b0}}};
    for (int i = 0; i < 3; i++) begin
      if (fb_act[i]) begin
        fb_sum = fb_sum + (W+2)'(conv_fb[i]);
        n_fb   = n_fb + 2'h1;
        if (conv_fb[i] < fb_min) fb_min = conv_fb[i];
        if (conv_fb[i] > fb_max) fb_max = conv_fb[i];
      end
      if (setpoint_used[i]) begin
        sp_sum = sp_sum + (W+2)'($signed(setpoints[i*W +: W]));
        n_sp   = n_sp + 2'h1;
      end
    end
    sp_comb = sp_sum;
    fb_comb = fb_sum;
    unique case (clpid_pkg::clpid_func_e'(cfg.func))
      clpid_pkg::CLPID_FN_DIFF:
        fb_comb = (W+2)'(conv_fb[0]) - (W+2)'(conv_fb[1]);
      clpid_pkg::CLPID_FN_AVG: begin
        fb_comb = (n_fb == 2'h3) ? (W+2)'(fb_sum / 3) : (n_fb == 2'h2) ? fb_sum >>> 1 : fb_sum;
        sp_comb = (n_sp == 2'h3) ? (W+2)'(sp_sum / 3) : (n_sp == 2'h2) ? sp_sum >>> 1 : sp_sum;
      end
      clpid_pkg::CLPID_FN_MIN: fb_comb = (n_fb == 2'h0) ? '0 : (W+2)'(fb_min);
      clpid_pkg::CLPID_FN_MAX: fb_comb = (n_fb == 2'h0) ? '0 : (W+2)'(fb_max);
      default: ;
    endcase
    sp_comb = sp_comb + (W+2)'(ext_ref);
  end

  // Error: setpoint minus feedback, sign flipped for inverse sense
  logic signed [W+2:0] err_raw;
  logic signed [W-1:0] err_sat;
  always_comb begin
    err_raw = (W+3)'(sp_comb) - (W+3)'(fb_comb);
    if (cfg.sense == `CLPID_SENSE_INVERSE)
      err_raw = -err_raw;
    if (err_raw > (W+3)'(SMAX))
      err_sat = W'(SMAX);
    else if (err_raw < (W+3)'(-SMAX))
      err_sat = W'(-SMAX);
    else
      err_sat = err_raw[W-1:0];
  end

  // Control tick
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      tick_reg  <= '0;
      state_reg <= clpid_pkg::CLPID_ST_IDLE;
    end else if (clk_en) begin
      unique case (state_reg)
        clpid_pkg::CLPID_ST_IDLE:
          if (tick_reg >= 32'(TICK_CYC - 1)) begin
            tick_reg  <= '0;
            state_reg <= clpid_pkg::CLPID_ST_ERR;
          end else begin
            tick_reg  <= tick_reg + 32'h1;
          end
        clpid_pkg::CLPID_ST_ERR: begin
          tick_reg  <= tick_reg + 32'h1;
          state_reg <= clpid_pkg::CLPID_ST_OUT;
        end
        clpid_pkg::CLPID_ST_OUT: begin
          tick_reg  <= tick_reg + 32'h1;
          state_reg <= clpid_pkg::CLPID_ST_IDLE;
        end
        default: state_reg <= clpid_pkg::CLPID_ST_IDLE;
      endcase
    end
  end

  // Integrator: error accumulated in a fraction register; one whole
  // count reaches the integrator per ti_s control ticks of unit error.
  logic integ_on;
  assign integ_on = (cfg.ti_s < `CLPID_TI_MAX_S) && (cfg.ti_s != 16'h0);
  // Widened with a zero sign bit: an unsigned operand would turn the compares
  // below unsigned and make a negative error count the integrator up
  logic signed [AW-1:0] ti_ext;
  assign ti_ext = AW'($signed({1'b0, cfg.ti_s}));
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      integ_reg <= '0;
      frac_reg  <= '0;
      err_value <= '0;
    end else if (clk_en && state_reg == clpid_pkg::CLPID_ST_ERR) begin
      err_value <= err_sat;
      if (!integ_on) begin
        integ_reg <= '0;
        frac_reg  <= '0;
      end else if (frac_reg + AW'(err_sat) >= ti_ext) begin
        integ_reg <= integ_reg + AW'(1);
        frac_reg  <= frac_reg + AW'(err_sat) - ti_ext;
      end else if (frac_reg + AW'(err_sat) <= -ti_ext) begin
        integ_reg <= integ_reg - AW'(1);
        frac_reg  <= frac_reg + AW'(err_sat) + ti_ext;
      end else begin
        frac_reg  <= frac_reg + AW'(err_sat);
      end
    end
  end

  // Output: P term plus integrator, saturated
  logic signed [AW-1:0] pi_sum;
  assign pi_sum = AW'(err_value) * AW'($signed({1'b0, cfg.kp})) + integ_reg;
  always_ff @(posedge clock or posedge rst) begin
    if (rst) begin
      speed_corr  <= '0;
      speed_valid <= 1'b0;
      fb_value    <= '0;
      fb1_src_reg <= `CLPID_FB1_SRC_RST;
    end else if (clk_en) begin
      speed_valid <= (state_reg == clpid_pkg::CLPID_ST_OUT);
      fb1_src_reg <= chan_reg[0].src;
      if (state_reg == clpid_pkg::CLPID_ST_ERR)
        fb_value <= fb_comb[W-1:0];
      if (state_reg == clpid_pkg::CLPID_ST_OUT) begin
        if (pi_sum > AW'(SMAX))
          speed_corr <= W'(SMAX);
        else if (pi_sum < AW'(-SMAX))
          speed_corr <= W'(-SMAX);
        else
          speed_corr <= pi_sum[W-1:0];
      end
    end
  end
endmodule // clpid_core

// File: test/clpid_plant.sv
// Sensor side of the PI speed controller: five feedback sources and converted values.
// Assumes the bench sets one process level; each sensor reads it with its own offset.
`timescale 1ns/1ns
module clpid_plant #(
  parameter int W = 16
) (
  // Process level
  input wire logic signed [W-1:0] lvl,
  // Sensor readings
  output logic signed [W-1:0]     ain53,
  output logic signed [W-1:0]     ain54,
  output logic signed [W-1:0]     pulse29,
  output logic signed [W-1:0]     pulse33,
  output logic signed [W-1:0]     bus_fb,
  // Refrigerant stage, one value per channel
  output logic signed [3*W-1:0]   p2t_value
);
  // Distinct offsets, so a wrong source selection shows up
  assign ain53     = lvl + W'(1);
  assign ain54     = lvl;
  assign pulse29   = lvl + W'(2);
  assign pulse33   = lvl + W'(3);
  assign bus_fb    = lvl + W'(4);
  assign p2t_value = {lvl + W'(7), lvl + W'(6), lvl + W'(5)};
endmodule // clpid_plant

// File: test/clpid_core_chk.sv
// Port checker for the PI speed controller.
// Assumes one clock domain; bound into clpid_core below.
`timescale 1ns/1ns
`include "clpid_regs.svh"
module clpid_core_chk #(
  parameter int W        = 16,
  parameter int TICK_CYC = 8
) (
  // Clock and reset
  input wire logic                  clock,
  input wire logic                  rst,
  input wire logic                  clk_en,
  // Configuration
  input wire logic                  cfg_load,
  input wire clpid_pkg::clpid_cfg_s cfg,
  // Results
  input wire logic signed [W-1:0]   speed_corr,
  input wire logic                  speed_valid,
  input wire logic signed [W-1:0]   err_value,
  input wire logic [3:0]            fb1_src_reg
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  localparam int SMAX = 2**(W-1) - 1;
  // Gain seen at the output edge, and the clamped proportional output it gives
  logic        [15:0]  kp_q;
  logic signed [2*W:0] prod_full;
  logic signed [W-1:0] prod_exp;
  // Enabled cycles since the last output pulse
  logic        [31:0]  gap_cnt;
  always_ff @(posedge clock) begin
    kp_q <= cfg.kp;
  end
  always_comb begin
    prod_full = (2*W+1)'(err_value) * (2*W+1)'($signed({1'b0, kp_q}));
    if (prod_full > (2*W+1)'(SMAX))
      prod_exp = W'(SMAX);
    else if (prod_full < (2*W+1)'(-SMAX))
      prod_exp = W'(-SMAX);
    else
      prod_exp = prod_full[W-1:0];
  end
  always_ff @(posedge clock or posedge rst) begin
    if (rst)
      gap_cnt <= '0;
    else if (clk_en)
      gap_cnt <= speed_valid ? 32'h1 : gap_cnt + 32'h1;
  end
  sequence s_err_new; $changed(err_value) && clk_en; endsequence
  property p_err_out; s_err_new |=> speed_valid; endproperty
  a_err_out: assert property (p_err_out) else $error("output late");
  property p_gap; speed_valid && clk_en |=> !speed_valid [*7]; endproperty
  a_gap: assert property (p_gap) else $error("output too often");
  property p_en; $rose(speed_valid) |-> $past(clk_en); endproperty
  a_en: assert property (p_en) else $error("output while disabled");
  property p_frz; !clk_en |=> $stable(speed_valid) && $stable(err_value); endproperty
  a_frz: assert property (p_frz) else $error("state moved while disabled");
  property p_hold; !speed_valid |-> $stable(speed_corr); endproperty
  a_hold: assert property (p_hold) else $error("output moved off tick");
  property p_pgain; $rose(speed_valid) && $past(clk_en, 2)
    && $past(cfg.ti_s) == `CLPID_TI_MAX_S && $past(cfg.ti_s, 2) == `CLPID_TI_MAX_S
    |-> speed_corr == prod_exp; endproperty
  a_pgain: assert property (p_pgain) else $error("bad proportional output");
  property p_load; $changed(fb1_src_reg) |-> $past(cfg_load && clk_en, 2); endproperty
  a_load: assert property (p_load) else $error("source changed unloaded");
  property p_rst; $fell(rst) |-> fb1_src_reg == `CLPID_FB1_SRC_RST && speed_corr == '0
    && !speed_valid; endproperty
  a_rst: assert property (p_rst) else $error("bad reset state");
  property p_period; speed_valid && clk_en
    |-> gap_cnt == 32'(TICK_CYC) || gap_cnt == 32'(TICK_CYC + 2); endproperty
  a_period: assert property (p_period) else $error("tick period wrong");
endmodule // clpid_core_chk
bind clpid_core clpid_core_chk #(.W(W), .TICK_CYC(TICK_CYC)) chk (
  .clock(clock), .rst(rst), .clk_en(clk_en), .cfg_load(cfg_load), .cfg(cfg),
  .speed_corr(speed_corr), .speed_valid(speed_valid), .err_value(err_value),
  .fb1_src_reg(fb1_src_reg));

// File: test/tb_top.sv
// Self-checking bench for the PI speed controller.
// Assumes the sensor model and the bound checker.
`timescale 1ns/1ns
`include "clpid_regs.svh"
module tb_top;
  localparam int W = 16;
  logic                         clock = 1'b0, rst = 1'b1, clk_en = 1'b1, cfg_load = 1'b0;
  logic                         speed_valid;
  logic [2:0]                   setpoint_used = 3'h1;
  logic [3:0]                   fb1_src_reg;
  logic signed [W-1:0]          lvl = '0, ext_ref = '0, e, f, speed_corr, fb_value, err_value;
  logic signed [W-1:0]          ain53, ain54, pulse29, pulse33, bus_fb;
  logic signed [3*W-1:0]        p2t_value, setpoints = '0;
  clpid_pkg::clpid_chan_s [2:0] chan_cfg = '0;
  clpid_pkg::clpid_cfg_s        cfg = '0;
  int                           bad_count = 0, compares = 0, seed = 1904, cyc = 0, i;
  always #20 clock = ~clock;
  clpid_plant #(.W(W)) plant (.lvl(lvl), .ain53(ain53), .ain54(ain54), .pulse29(pulse29),
    .pulse33(pulse33), .bus_fb(bus_fb), .p2t_value(p2t_value));
  clpid_core #(.W(W), .TICK_CYC(8)) dut (.clock(clock), .rst(rst), .clk_en(clk_en),
    .ain53(ain53), .ain54(ain54), .pulse29(pulse29), .pulse33(pulse33), .bus_fb(bus_fb),
    .p2t_value(p2t_value), .cfg_load(cfg_load), .chan_cfg(chan_cfg), .cfg(cfg),
    .setpoints(setpoints), .setpoint_used(setpoint_used), .ext_ref(ext_ref),
    .speed_corr(speed_corr), .speed_valid(speed_valid), .fb_value(fb_value),
    .err_value(err_value), .fb1_src_reg(fb1_src_reg));
  task automatic finish_test;
    if (bad_count == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic chk(logic [W-1:0] got, logic [W-1:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Bounded by the cycle ceiling below
  task automatic tick;
    do @(negedge clock); while (speed_valid !== 1'b1);
  endtask
  function automatic logic signed [W-1:0] exp_fb(int fn, logic signed [W-1:0] a, b, c);
    logic signed [W-1:0] lo, hi;
    lo = (a < b) ? a : b;
    lo = (lo < c) ? lo : c;
    hi = (a > b) ? a : b;
    hi = (hi > c) ? hi : c;
    case (fn)
      0: return a + b + c;
      1: return a - b;
      2: return (a + b + c) / W'(3);
      3: return lo;
      default: return hi;
    endcase
  endfunction
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 2000) begin
      bad_count++;
      finish_test;
    end
  end
  initial begin
    cfg.ti_s = `CLPID_TI_MAX_S;
    repeat (8) @(negedge clock);
    rst = 1'b0;
    chk(W'(fb1_src_reg), W'(`CLPID_FB1_SRC_RST));
    for (i = 0; i < 12; i++) begin
      lvl = W'($random(seed) % 200);
      ext_ref = W'($random(seed) % 50);
      // First pass: reference equals feedback, zero error
      setpoints[W-1:0] = (i == 0) ? lvl - ext_ref : W'($random(seed) % 200);
      cfg.kp = W'($unsigned($random(seed)) % 40);
      cfg.sense = 1'(i);
      tick;
      e = cfg.sense ? lvl - setpoints[W-1:0] - ext_ref : setpoints[W-1:0] + ext_ref - lvl;
      chk(fb_value, lvl);
      chk(err_value, e);
      chk(speed_corr, W'(e * $signed({1'b0, cfg.kp})));
    end
    cfg.kp = '0;
    chan_cfg[0] = '{`CLPID_SRC_AIN53, `CLPID_CONV_LINEAR};
    chan_cfg[1] = '{`CLPID_SRC_PULSE29, `CLPID_CONV_P2T};
    chan_cfg[2] = '{`CLPID_SRC_BUS, `CLPID_CONV_LINEAR};
    lvl = W'($unsigned($random(seed)) % 100);
    cfg_load = 1'b1;
    cfg.sense = `CLPID_SENSE_NORMAL;
    ext_ref = '0;
    setpoint_used = 3'h7;
    setpoints = {W'($random(seed) % 100), W'($random(seed) % 100), W'($random(seed) % 100)};
    e = setpoints[W-1:0] + setpoints[2*W-1:W] + setpoints[3*W-1:2*W];
    @(negedge clock);
    cfg_load = 1'b0;
    // The source register trails the stored channel set by one edge
    @(negedge clock);
    chk(W'(fb1_src_reg), W'(`CLPID_SRC_AIN53));
    for (i = 0; i < 5; i++) begin
      cfg.func = 3'(i);
      tick;
      f = exp_fb(i, lvl + W'(1), lvl + W'(6), lvl + W'(4));
      chk(fb_value, f);
      chk(err_value, ((i == 2) ? e / W'(3) : e) - f);
    end
    cfg.func = 3'h0;
    cfg.ti_s = 16'h4;
    setpoint_used = 3'h1;
    setpoints[W-1:0] = W'(3) * lvl + W'(61);
    tick;
    f = speed_corr;
    repeat (3) begin
      tick;
      chk(W'(speed_corr > f), W'(1));
      f = speed_corr;
    end
    rst = 1'b1;
    @(negedge clock);
    chk(speed_corr, '0);
    chk(W'(fb1_src_reg), W'(`CLPID_FB1_SRC_RST));
    rst = 1'b0;
    cfg.sense = 1'b1;
    f = '0;
    repeat (3) begin
      tick;
      chk(W'(speed_corr < f), W'(1));
      f = speed_corr;
    end
    @(negedge clock);
    clk_en = 1'b0;
    repeat (30) begin
      @(negedge clock);
      chk(W'(speed_valid), '0);
    end
    clk_en = 1'b1;
    tick;
    finish_test;
  end
endmodule // tb_top
